// ---- design/cfg_addr_format.sv ----
// Builds the PCI address of a configuration cycle from the host address.
// Assumes the bus-select extension is stable while a request is taken.
`timescale 1ns/100ps
`default_nettype none
module cfg_addr_format (
	input  wire logic [28:7] host_cfg_addr_i,
	input  wire logic [1:0]  bus_sel_i,
	output logic      [31:0] pci_addr_o
);
	logic [xlate_pkg::IDSEL_COUNT-1:0] idsel;
	// Device numbers 21 and up select nothing
	for (genvar i = 0; i < xlate_pkg::IDSEL_COUNT; i++) begin : g_idsel
		assign idsel[i] = (host_cfg_addr_i[20:16] == 5'(i)); // R4
	end
	always_comb begin
		if (bus_sel_i == xlate_pkg::BUS_PRIMARY) begin
			pci_addr_o = {idsel, host_cfg_addr_i[15:7], bus_sel_i}; // R2 R3 R4 R24
		end else begin
			pci_addr_o = {8'h00, host_cfg_addr_i[28:7], bus_sel_i}; // R5 R25 R24
		end
	end
endmodule : cfg_addr_format
`default_nettype wire

// ---- design/host_to_pci_cfg_sparse_xlate.sv ----
// Host-to-PCI translation for configuration and sparse memory spaces.
// Assumes a same-clock host request port and a PCI master that signals done.
`timescale 1ns/100ps
`default_nettype none
module host_to_pci_cfg_sparse_xlate (
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        req_valid_i,
	input  wire logic        req_write_i,
	input  wire logic [33:5] host_addr_bus_i,
	input  wire logic [7:0]  lw_mask_i,
	input  wire logic [4:0]  prog_upper_addr_ext_i,
	input  wire logic [1:0]  cfg_bus_select_ext_i,
	input  wire logic        pci_done_i,
	output logic             req_ready_o,
	output logic             host_ack_o,
	output logic             pci_valid_o,
	output logic      [3:0]  pci_cmd_o,
	output logic      [31:0] pci_addr_o,
	output logic      [3:0]  pci_be_n_o,
	output logic             pci_quad_o,
	output logic             pci_undef_o
);
	typedef struct packed {
		xlate_pkg::phase_type phase;
		logic [3:0]           cmd;
		logic [31:0]          addr;
		logic [3:0]           be_n;
		logic                 quad;
		logic                 undef;
	} state_type;

	state_type state;
	state_type next_state;

	logic [1:0]  len;
	logic [3:0]  be_n;
	logic        quad;
	logic        invalid;
	logic [31:0] cfg_addr;
	logic [4:0]  upper;
	logic        is_cfg;
	logic        is_sparse;
	logic        accept;

	// Bits 4:3 never leave the host core; rebuild them from the masks
	always_comb begin
		if (!req_write_i) begin
			len = lw_mask_i[1:0]; // R18
		end else if (lw_mask_i[7:6] != 2'h0) begin
			len = 2'h3; // R17
		end else if (lw_mask_i[5:4] != 2'h0) begin
			len = 2'h2; // R17
		end else if (lw_mask_i[3:2] != 2'h0) begin
			len = 2'h1; // R17
		end else begin
			len = 2'h0; // R17
		end
	end

	// One decoder serves both spaces, so config masks match sparse ones
	sparse_lane_decode u_lane (
		.len_i     (len),
		.lane_i    (host_addr_bus_i[6:5]), // R13 R6
		.be_n_o    (be_n),
		.quad_o    (quad),
		.invalid_o (invalid)
	);

	cfg_addr_format u_cfg (
		.host_cfg_addr_i (host_addr_bus_i[28:7]),
		.bus_sel_i       (cfg_bus_select_ext_i),
		.pci_addr_o      (cfg_addr)
	);

	assign is_sparse = (host_addr_bus_i[33:32] == xlate_pkg::SPACE_SPARSE_MEM); // R9
	assign is_cfg    = (host_addr_bus_i[33:32] == xlate_pkg::SPACE_CFG_IO)
	                && (host_addr_bus_i[31:29] == xlate_pkg::CFG_REGION_HI);
	assign req_ready_o = (state.phase == xlate_pkg::ST_IDLE);
	assign accept      = req_valid_i && req_ready_o;

	// Lowest 16MB always lands at PCI zero for legacy memory holes
	assign upper = (host_addr_bus_i[31:29] == xlate_pkg::FIXED_REGION_HI)
	             ? xlate_pkg::fixed_upper_addr_ext : prog_upper_addr_ext_i; // R11 R12

	always_comb begin
		next_state = state;
		unique case (state.phase)
			xlate_pkg::ST_IDLE: begin
				if (accept && is_sparse) begin
					next_state.phase = xlate_pkg::ST_CYCLE;
					next_state.cmd   = req_write_i ? xlate_pkg::CMD_MEM_WRITE
					                               : xlate_pkg::CMD_MEM_READ; // R9
					next_state.addr  = {upper, host_addr_bus_i[31:8],
					                    host_addr_bus_i[7] & ~quad, 2'h0}; // R10 R15
					next_state.be_n  = be_n; // R14
					next_state.quad  = quad;
					next_state.undef = invalid; // R16
				end else if (accept && is_cfg) begin
					next_state.phase = xlate_pkg::ST_CYCLE;
					next_state.cmd   = req_write_i ? xlate_pkg::CMD_CFG_WRITE
					                               : xlate_pkg::CMD_CFG_READ;
					next_state.addr  = cfg_addr; // R2 R3 R4 R5
					next_state.be_n  = be_n; // R6
					next_state.quad  = quad;
					next_state.undef = invalid;
				end else if (accept) begin
					// Spaces outside this block are acknowledged without a cycle
					next_state.phase = xlate_pkg::ST_ACK;
				end
			end
			xlate_pkg::ST_CYCLE: begin
				// Invalid combinations still run and are acked after pci_done_i
				if (pci_done_i) begin
					next_state.phase = xlate_pkg::ST_ACK; // R16
				end
			end
			xlate_pkg::ST_ACK: begin
				next_state.phase = xlate_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '{xlate_pkg::ST_IDLE, 4'h0, 32'h0, xlate_pkg::BE_N_NONE, 1'b0, 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign pci_valid_o = (state.phase == xlate_pkg::ST_CYCLE);
	assign host_ack_o  = (state.phase == xlate_pkg::ST_ACK);
	assign pci_cmd_o   = state.cmd;
	assign pci_addr_o  = state.addr;
	assign pci_be_n_o  = state.be_n;
	assign pci_quad_o  = state.quad;
	assign pci_undef_o = state.undef;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_sparse_cmd_dir: assert property ( // R9
		accept && is_sparse |=> pci_valid_o
		&& pci_cmd_o == ($past(req_write_i) ? xlate_pkg::CMD_MEM_WRITE
		                                     : xlate_pkg::CMD_MEM_READ))
		else $error("sparse access did not start a matching memory cycle");

	a_sparse_addr_map: assert property ( // R10
		accept && is_sparse |=> pci_addr_o[26:3] == $past(host_addr_bus_i[31:8]))
		else $error("sparse address bits 26:3 wrong");

	a_fixed_ext_zero: assert property ( // R11
		accept && is_sparse && host_addr_bus_i[31:29] == 3'h0
		|=> pci_addr_o[31:27] == 5'h00)
		else $error("low 16MB not mapped to PCI zero");

	a_prog_ext_used: assert property ( // R12
		accept && is_sparse && host_addr_bus_i[31:29] != 3'h0
		|=> pci_addr_o[31:27] == $past(prog_upper_addr_ext_i))
		else $error("programmable extension not applied");

	a_sparse_low_bits: assert property ( // R15
		accept && is_sparse |=> pci_addr_o[1:0] == 2'h0
		&& pci_addr_o[2] == ($past(host_addr_bus_i[7]) && !pci_quad_o))
		else $error("sparse address bits 2:0 wrong");

	a_byte_lane_be: assert property ( // R14
		accept && is_sparse && len == 2'h0 |=> pci_be_n_o
		== ~(4'h1 << $past(host_addr_bus_i[6:5])))
		else $error("byte enable for byte access wrong");

	a_write_len_rebuild: assert property ( // R17
		accept && (is_sparse || is_cfg) && req_write_i && lw_mask_i == 8'h04
		&& host_addr_bus_i[6:5] == 2'h0
		|=> pci_be_n_o == 4'hC)
		else $error("write length not rebuilt from mask");

	a_primary_idsel: assert property ( // R4
		accept && is_cfg && cfg_bus_select_ext_i == 2'h0
		|=> $onehot0(pci_addr_o[31:11]) && pci_addr_o[1:0] == 2'h0)
		else $error("primary config select not one-hot");

	a_secondary_fmt: assert property ( // R25
		accept && is_cfg && cfg_bus_select_ext_i == 2'h1
		|=> pci_addr_o[31:24] == 8'h00 && pci_addr_o[1:0] == 2'h1
		&& pci_addr_o[23:2] == $past(host_addr_bus_i[28:7]))
		else $error("secondary config address wrong");

	a_cfg_reg_func: assert property ( // R2
		accept && is_cfg |=> pci_addr_o[10:2] == $past(host_addr_bus_i[15:7]))
		else $error("config function or register field wrong");

	a_invalid_acked: assert property ( // R16
		pci_valid_o && pci_undef_o && pci_done_i |=> host_ack_o ##1 req_ready_o)
		else $error("invalid combination not completed");

	// Configuration field placement, command and byte enables
	a_func_select_map: assert property ( // R3
		accept && is_cfg |=> pci_addr_o[10:8] == $past(host_addr_bus_i[15:13]))
		else $error("config function number field wrong");

	a_idsel_decode: assert property ( // R4
		accept && is_cfg && cfg_bus_select_ext_i == 2'h0
		&& host_addr_bus_i[20:16] < 5'h15
		|=> pci_addr_o[31:11] == (21'h000001 << $past(host_addr_bus_i[20:16])))
		else $error("primary device select line wrong");

	a_idsel_none: assert property ( // R4
		accept && is_cfg && cfg_bus_select_ext_i == 2'h0
		&& host_addr_bus_i[20:16] >= 5'h15
		|=> pci_addr_o[31:11] == 21'h000000)
		else $error("out-of-range device drove a select line");

	a_bus_select_low: assert property ( // R24
		accept && is_cfg |=> pci_addr_o[1:0] == $past(cfg_bus_select_ext_i))
		else $error("config low bits not from bus select");

	a_secondary_bus_num: assert property ( // R5
		accept && is_cfg && cfg_bus_select_ext_i != 2'h0
		|=> pci_addr_o[31:24] == 8'h00
		&& pci_addr_o[23:16] == $past(host_addr_bus_i[28:21]))
		else $error("secondary bus number field wrong");

	a_cfg_cmd_dir: assert property ( // R1
		accept && is_cfg |=> pci_valid_o
		&& pci_cmd_o == ($past(req_write_i) ? xlate_pkg::CMD_CFG_WRITE
		                                     : xlate_pkg::CMD_CFG_READ))
		else $error("config access did not start a config cycle");

	a_cfg_byte_mask: assert property ( // R6
		accept && is_cfg && !req_write_i && lw_mask_i[1:0] == 2'h3
		&& host_addr_bus_i[6:5] == 2'h0
		|=> pci_be_n_o == 4'h0 && !pci_undef_o)
		else $error("config byte enables not decoded like sparse");

	// Spot checks of the length and lane table
	a_word_lane_be: assert property ( // R14
		accept && (is_sparse || is_cfg) && len == 2'h1 && host_addr_bus_i[6:5] == 2'h1
		|=> pci_be_n_o == 4'h9)
		else $error("word byte enables wrong");

	a_tribyte_be: assert property ( // R14
		accept && (is_sparse || is_cfg) && len == 2'h2 && host_addr_bus_i[6:5] == 2'h1
		|=> pci_be_n_o == 4'h1)
		else $error("tribyte byte enables wrong");

	a_long_quad_be: assert property ( // R14
		accept && (is_sparse || is_cfg) && len == 2'h3
		&& (host_addr_bus_i[6:5] == 2'h0 || host_addr_bus_i[6:5] == 2'h3)
		|=> pci_be_n_o == 4'h0 && !pci_undef_o)
		else $error("longword or quadword byte enables wrong");

	a_invalid_flagged: assert property ( // R16
		accept && (is_sparse || is_cfg)
		&& ((len == 2'h1 && host_addr_bus_i[6:5] == 2'h3)
		|| (len == 2'h2 && host_addr_bus_i[6])
		|| (len == 2'h3 && host_addr_bus_i[6] != host_addr_bus_i[5]))
		|=> pci_undef_o && pci_be_n_o == 4'hF)
		else $error("invalid combination not flagged");

	a_quad_detect: assert property ( // R13
		accept && is_sparse |=> pci_quad_o
		== ($past(len) == 2'h3 && $past(host_addr_bus_i[6:5]) == 2'h3))
		else $error("quadword access not recognised");

	a_read_len_mask: assert property ( // R18
		accept && is_sparse && !req_write_i && lw_mask_i[1:0] == 2'h0
		&& host_addr_bus_i[6:5] == 2'h2 |=> pci_be_n_o == 4'hB)
		else $error("read length not taken from mask");

	a_write_quad_mask: assert property ( // R17
		accept && is_sparse && req_write_i && lw_mask_i == 8'hC0
		&& host_addr_bus_i[6:5] == 2'h3
		|=> pci_quad_o && pci_addr_o[2:0] == 3'h0)
		else $error("quadword write not rebuilt from mask");

	// Handshake sequencing
	// A target that never ends its cycle stalls the host; no timeout here
	a_cycle_after_take: assert property ( // R9
		accept && (is_sparse || is_cfg) |=> pci_valid_o && !req_ready_o)
		else $error("mapped access did not start a cycle");

	a_cycle_holds: assert property ( // R9
		pci_valid_o && !pci_done_i |=> pci_valid_o && $stable(pci_addr_o)
		&& $stable(pci_cmd_o) && $stable(pci_be_n_o))
		else $error("cycle dropped or changed before done");

	a_done_to_ack: assert property ( // R16
		pci_valid_o && pci_done_i |=> host_ack_o && !pci_valid_o)
		else $error("done not followed by host acknowledge");

	a_ack_one_pulse: assert property ( // R16
		host_ack_o |=> !host_ack_o && req_ready_o)
		else $error("acknowledge not a single pulse");

	a_unmapped_ack: assert property ( // R9
		accept && !is_sparse && !is_cfg |=> host_ack_o && !pci_valid_o)
		else $error("unmapped access not acknowledged");

	c_sparse_quad: cover property (accept && is_sparse && quad ##1 pci_valid_o);
	c_cfg_secondary: cover property (accept && is_cfg && cfg_bus_select_ext_i == 2'h1);
	c_invalid_combo: cover property (pci_valid_o && pci_undef_o ##1 host_ack_o);
	c_cfg_primary: cover property (accept && is_cfg && cfg_bus_select_ext_i == 2'h0);
	c_unmapped_ack: cover property (accept && !is_sparse && !is_cfg ##1 host_ack_o);
endmodule : host_to_pci_cfg_sparse_xlate
`default_nettype wire

// ---- design/sparse_lane_decode.sv ----
// Length and lane decode into active-low PCI byte enables.
// Assumes len and lane are already recovered host address bits 4:3 and 6:5.
`timescale 1ns/100ps
`default_nettype none
module sparse_lane_decode (
	input  wire logic [1:0] len_i,
	input  wire logic [1:0] lane_i,
	output logic      [3:0] be_n_o,
	output logic            quad_o,
	output logic            invalid_o
);
	always_comb begin
		be_n_o    = xlate_pkg::BE_N_NONE;
		quad_o    = 1'b0;
		invalid_o = 1'b0;
		unique case (len_i)
			xlate_pkg::LEN_BYTE: begin
				be_n_o = ~(xlate_pkg::MASK_BYTE << lane_i); // R14
			end
			xlate_pkg::LEN_WORD: begin
				if (lane_i != 2'h3) begin
					be_n_o = ~(xlate_pkg::MASK_WORD << lane_i); // R14
				end else begin
					invalid_o = 1'b1; // R16
				end
			end
			xlate_pkg::LEN_TRIBYTE: begin
				if (lane_i[1] == 1'b0) begin
					be_n_o = ~(xlate_pkg::MASK_TRIBYTE << lane_i); // R14
				end else begin
					invalid_o = 1'b1; // R16
				end
			end
			xlate_pkg::LEN_LONG: begin
				if (lane_i == 2'h0 || lane_i == xlate_pkg::LANE_QUAD) begin
					be_n_o = xlate_pkg::BE_N_ALL; // R14
					quad_o = (lane_i == xlate_pkg::LANE_QUAD);
				end else begin
					invalid_o = 1'b1; // R16
				end
			end
		endcase
	end
endmodule : sparse_lane_decode
`default_nettype wire

// ---- design/xlate_pkg.sv ----
// Constants, types and encodings shared by the host-to-PCI translation block.
// Assumes the host side presents byte address bits 33:5 plus longword masks.
// Summary of operation
// R1: Primary target takes a config cycle on select, config command and low bits 00.
// R2: PCI address bits 7:2 come from host config address bits 12:7.
// R3: PCI address bits 10:8 come from host config address bits 15:13.
// R4: Primary config: host bits 20:16 decode one-hot onto PCI 31:11; 28:21 ignored.
// R5: Secondary config: low bits 01, host 28:7 map onto PCI 23:2.
// R6: Config byte enables use the same length and lane decode as sparse space.
// R7: Bridge owning the bus number intercepts config cycles with low bits 01.
// R8: Bridge forwards unmodified cycles for buses in its subordinate range.
// R9: Host bits 33:32 select space; sparse memory gives PCI memory read or write.
// R10: Sparse memory: host bits 31:8 drive PCI address bits 26:3.
// R11: PCI bits 31:27 are zero when host 31:29 is zero, else programmable.
// R12: Sparse space spans 128MB: lowest 16MB fixed at zero, rest relocatable.
// R13: Length from host bits 4:3, starting lane from host bits 6:5.
// R14: Byte enables are active low per lane, per the length and lane table.
// R15: Sparse PCI bits 1:0 are 00, bit 2 from host bit 7; quadword 000.
// R16: Invalid length and lane combinations still complete; data undefined.
// R17: Writes rebuild host bits 4:3 from which longword mask pair is nonzero.
// R18: Reads take host bits 4:3 from longword mask bits 1:0.
// R19: Sub-quadword writes present exactly one mask pair equal to 01.
// R20: Quadword writes present longword mask 11000000 only.
// R21: Software places a memory barrier after every sparse write.
// R22: Sub-quadword stores go to the lower longword of the quadword.
// R23: Sub-quadword loads use a lower-longword load.
// R24: Config low bits 1:0 come from the bus-select extension value.
// R25: Secondary config cycles force PCI address bits 31:24 to zero.
package xlate_pkg;
	localparam logic [1:0] SPACE_CFG_IO      = 2'h1;
	localparam logic [1:0] SPACE_SPARSE_MEM  = 2'h2;
	localparam logic [2:0] CFG_REGION_HI     = 3'h7;
	localparam logic [2:0] FIXED_REGION_HI   = 3'h0;
	localparam logic [4:0] fixed_upper_addr_ext = 5'h00;
	localparam logic [1:0] BUS_PRIMARY       = 2'h0;
	localparam logic [1:0] BUS_SECONDARY     = 2'h1;
	localparam int         IDSEL_LSB         = 11;
	localparam int         IDSEL_COUNT       = 21;
	localparam logic [1:0] LEN_BYTE          = 2'h0;
	localparam logic [1:0] LEN_WORD          = 2'h1;
	localparam logic [1:0] LEN_TRIBYTE       = 2'h2;
	localparam logic [1:0] LEN_LONG          = 2'h3;
	localparam logic [1:0] LANE_QUAD         = 2'h3;
	localparam logic [3:0] BE_N_ALL          = 4'h0;
	localparam logic [3:0] BE_N_NONE         = 4'hF;
	localparam logic [3:0] MASK_BYTE         = 4'h1;
	localparam logic [3:0] MASK_WORD         = 4'h3;
	localparam logic [3:0] MASK_TRIBYTE      = 4'h7;
	localparam logic [3:0] CMD_MEM_READ      = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
	localparam logic [3:0] CMD_CFG_READ      = 4'hA;
	localparam logic [3:0] CMD_CFG_WRITE     = 4'hB;
	localparam logic [7:0] QUAD_WRITE_MASK   = 8'hC0;
	typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_ACK} phase_type;
endpackage : xlate_pkg

// ---- tb/pci_target_model.sv ----
// Far-side PCI target: claims a cycle and ends it after a set delay.
// Assumes the bridge holds its cycle request until done is seen.
`timescale 1ns/100ps
`default_nettype none
module pci_target_model (
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        pci_valid_i,
	input  wire logic [3:0]  pci_cmd_i,
	input  wire logic [31:0] pci_addr_i,
	input  wire logic [7:0]  lat_i,
	output logic             pci_done_o,
	output logic             claim_o
);
	logic [7:0] cnt;
	// Config claimed on 00 by a primary target, on 01 by a bridge
	assign claim_o = pci_valid_i & (~pci_cmd_i[3] | (pci_addr_i[1:0] <= 2'h1));
	// An unclaimed cycle never ends, so the bench sees it as a hang
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt        <= 8'h00;
			pci_done_o <= 1'b0;
		end else begin
			pci_done_o <= claim_o & ~pci_done_o & (cnt == lat_i);
			cnt        <= (pci_valid_i & ~pci_done_o) ? cnt + 8'h01 : 8'h00;
		end
	end
endmodule : pci_target_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the host-to-PCI translation block.
// Assumes the target model ends every claimed cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        mclk_i    = 1'b0;
	logic        arst_n_i  = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [33:0] haddr     = 34'h0;
	logic [7:0]  mask      = 8'h00;
	logic [4:0]  ext       = 5'h15;
	logic [1:0]  bsel      = 2'h0;
	logic [7:0]  lat       = 8'h01;
	logic        done, claim, ready, ack, pv, quad, undef;
	logic [3:0]  cmd, be_n;
	logic [31:0] paddr;
	int          mismatches = 0;
	int          compares   = 0;
	// {undef, be_n} by {len, lane}; 1F marks the invalid combinations
	localparam logic [4:0] BE_TAB [16] = '{5'h0E, 5'h0D, 5'h0B, 5'h07, 5'h0C, 5'h09, 5'h03,
		5'h1F, 5'h08, 5'h01, 5'h1F, 5'h1F, 5'h00, 5'h1F, 5'h1F, 5'h00};
	always #5 mclk_i = ~mclk_i;
	host_to_pci_cfg_sparse_xlate host_to_pci_cfg_sparse_xlate_inst (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid),
		.req_write_i(req_write), .host_addr_bus_i(haddr[33:5]), .lw_mask_i(mask),
		.prog_upper_addr_ext_i(ext), .cfg_bus_select_ext_i(bsel), .pci_done_i(done),
		.req_ready_o(ready), .host_ack_o(ack), .pci_valid_o(pv), .pci_cmd_o(cmd),
		.pci_addr_o(paddr), .pci_be_n_o(be_n), .pci_quad_o(quad), .pci_undef_o(undef)
	);
	pci_target_model pci_target_model_inst (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pci_valid_i(pv), .pci_cmd_i(cmd),
		.pci_addr_i(paddr), .lat_i(lat), .pci_done_o(done), .claim_o(claim)
	);
	task automatic tally_and_finish;
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang(input int n);
		if (n >= 60) begin
			mismatches++;
			$display("unexpected at %0t: wait timed out", $time);
			tally_and_finish();
		end
	endtask : hang
	function automatic logic [31:0] spa(input logic [33:0] a);
		return {(a[31:29] == 3'h0) ? 5'h00 : ext, a[31:8], a[7], 2'h0};
	endfunction : spa
	// A zero command marks an unmapped access: ack with no PCI cycle
	task automatic xfer(input logic [33:0] a, input logic w, input logic [7:0] m,
		input logic [3:0] ec, input logic [31:0] ea);
		int         n;
		logic [1:0] len;
		logic [4:0] e;
		logic       q;
		n = 0;
		while (ready !== 1'b1 && n < 60) begin
			@(negedge mclk_i);
			n++;
		end
		hang(n);
		haddr     = a;
		req_write = w;
		mask      = m;
		req_valid = 1'b1;
		@(negedge mclk_i);
		req_valid = 1'b0;
		if (ec == 4'h0) begin
			chk(ack, 1'b1);
			chk(pv, 1'b0);
			return;
		end
		len = w ? (|m[7:6] ? 2'h3 : |m[5:4] ? 2'h2 : |m[3:2] ? 2'h1 : 2'h0) : m[1:0];
		e   = BE_TAB[{len, a[6:5]}];
		q   = ({len, a[6:5]} == 4'hF);
		chk(pv, 1'b1);
		chk(ready, 1'b0);
		chk(claim, 1'b1);
		chk(cmd, ec);
		chk(paddr, q ? ea & 32'hFFFF_FFFB : ea);
		chk(be_n, e[3:0]);
		chk(undef, e[4]);
		chk(quad, q);
		n = 0;
		while (ack !== 1'b1 && n < 60) begin
			@(negedge mclk_i);
			n++;
		end
		hang(n);
		chk(pv, 1'b0);
	endtask : xfer
	task automatic sc_sparse_rd;
		logic [33:0] a;
		for (int i = 0; i < 16; i++) begin
			a = 34'h2_00AB_CD80 | (34'(i % 4) << 5) ^ (34'(i % 2) << 7);
			xfer(a, 1'b0, 8'(i / 4), xlate_pkg::CMD_MEM_READ, spa(a));
		end
	endtask : sc_sparse_rd
	task automatic sc_sparse_wr;
		logic [33:0] a;
		for (int i = 0; i < 5; i++) begin
			a = {2'h2, 3'(i), 21'h12345, 1'b0, (i == 4) ? 2'h3 : 2'h0, 5'h00};
			xfer(a, 1'b1, (i == 4) ? 8'hC0 : 8'h01 << (2 * i), xlate_pkg::CMD_MEM_WRITE,
				spa(a));
		end
	endtask : sc_sparse_wr
	task automatic sc_cfg;
		logic [33:0] a;
		logic [31:0] ea;
		for (int s = 0; s < 2; s++) begin
			for (int d = 0; d < 23; d++) begin
				bsel = 2'(s);
				a    = {2'h1, 3'h7, 8'hA5, 5'(d), 3'h5, 6'h2A, 7'h00};
				ea   = (d < 21) ? 32'h800 << d : 32'h0;
				ea   = s ? {8'h00, a[28:7], 2'h1} : ea | {21'h0, a[15:7], 2'h0};
				xfer(a, d[0], d[0] ? 8'hC0 : 8'h03,
					d[0] ? xlate_pkg::CMD_CFG_WRITE : xlate_pkg::CMD_CFG_READ, ea);
			end
		end
		bsel = 2'h0;
	endtask : sc_cfg
	task automatic sc_unmapped;
		xfer(34'h0_1234_5600, 1'b0, 8'h03, 4'h0, 32'h0);
		xfer(34'h1_2000_0000, 1'b1, 8'h01, 4'h0, 32'h0);
		xfer(34'h3_0000_0100, 1'b0, 8'h00, 4'h0, 32'h0);
	endtask : sc_unmapped
	task automatic sc_slow;
		lat = 8'h0C;
		xfer(34'h2_E000_0020, 1'b0, 8'h01, xlate_pkg::CMD_MEM_READ, spa(34'h2_E000_0020));
		lat = 8'h00;
		xfer(34'h2_0000_00E0, 1'b1, 8'h01, xlate_pkg::CMD_MEM_WRITE, spa(34'h2_0000_00E0));
		lat = 8'h01;
	endtask : sc_slow
	// Reset dropped in the middle of a slow cycle, then a fresh request at once
	task automatic sc_midrun_reset;
		@(negedge mclk_i);
		chk(ready, 1'b1);
		haddr     = 34'h2_2000_0040;
		req_write = 1'b0;
		mask      = 8'h00;
		lat       = 8'h20;
		req_valid = 1'b1;
		@(negedge mclk_i);
		req_valid = 1'b0;
		chk(pv, 1'b1);
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'b0;
		@(negedge mclk_i);
		chk(pv, 1'b0);
		chk(ack, 1'b0);
		chk(ready, 1'b1);
		chk(cmd, 4'h0);
		chk(paddr, 32'h0);
		chk(be_n, 4'hF);
		chk(quad, 1'b0);
		chk(undef, 1'b0);
		lat      = 8'h01;
		arst_n_i = 1'b1;
		xfer(34'h2_2000_0040, 1'b0, 8'h00, xlate_pkg::CMD_MEM_READ,
			spa(34'h2_2000_0040));
	endtask : sc_midrun_reset
	initial begin
		repeat (10) @(negedge mclk_i);
		chk(ready, 1'b1);
		chk(pv, 1'b0);
		chk(be_n, 4'hF);
		arst_n_i = 1'b1;
		sc_sparse_rd();
		sc_sparse_wr();
		sc_cfg();
		sc_unmapped();
		sc_slow();
		sc_midrun_reset();
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
